// *** pkg/pmbapw_pkg.sv ***
// Package for the PMBus addressing, page and write-protect front end.
package pmbapw_pkg;
  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_PAGE_PLUS_WRITE = 8'h05;
  localparam logic [7:0] CMD_PAGE_PLUS_READ = 8'h06;
  localparam logic [7:0] CMD_WRITE_LOCK = 8'h10;
  localparam logic [7:0] CMD_STORE_USER_ALL = 8'h15;
  localparam logic [7:0] CMD_FEATURE_SUMMARY = 8'h19;
  localparam logic [7:0] CMD_VOUT_COMMAND = 8'h21;
  localparam logic [7:0] CMD_STATUS_FIRST = 8'h78;
  localparam logic [7:0] CMD_STATUS_LAST = 8'h80;
  localparam logic [7:0] CMD_PROTOCOL_REV = 8'h98;
  localparam logic [7:0] CMD_NVM_UNLOCK = 8'hBD;
  localparam logic [7:0] CMD_DEVICE_CONFIG = 8'hD1;
  localparam logic [7:0] CMD_PEAK_CLEAR = 8'hE3;
  localparam logic [7:0] CMD_DEVICE_ADDR = 8'hE6;
  localparam logic [7:0] CMD_RAIL_ADDR = 8'hFA;
  // ----------------------------------------------------------------
  // Values, resets and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_CH0 = 8'h00;
  localparam logic [7:0] PAGE_CH1 = 8'h01;
  localparam logic [7:0] PAGE_ALL = 8'hFF;
  localparam logic [7:0] WL_NONE = 8'h00;
  localparam logic [7:0] WL_HIGH = 8'h20;
  localparam logic [7:0] WL_MID = 8'h40;
  localparam logic [7:0] WL_FULL = 8'h80;
  localparam logic [7:0] ADDR_OFF = 8'h80;
  localparam logic [6:0] GLOBAL_ADDR_A = 7'h5A;
  localparam logic [6:0] GLOBAL_ADDR_B = 7'h5B;
  localparam logic [7:0] FEATURE_VALUE = 8'hB0;
  localparam logic [7:0] REVISION_VALUE = 8'h22;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] WL_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h01;
  localparam logic [7:0] DEV_ADDR_RESET = 8'h4F;
  localparam logic [7:0] RAIL_ADDR_RESET = 8'h80;
  localparam logic [9:0] PINS_OPEN_RESET = 10'h210;
  localparam int CFG_IGNORE_PINS_BIT = 6;
  localparam logic [3:0] PP_IDX_PAGE = 4'h1;
  localparam logic [3:0] PP_IDX_CODE = 4'h2;
  localparam logic [3:0] PP_IDX_DATA = 4'h3;
  localparam logic [7:0] EXT_BLOCK_LEN = 8'h02;
  localparam logic [7:0] LOCAL_BLOCK_LEN = 8'h01;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_CMD = 3'b001, ST_DATA = 3'b011, ST_READ = 3'b010, ST_DROP = 3'b110
  } pmbapw_state_t;

  // One event per cycle from the serial engine, same clock.
  typedef struct packed {
    logic start;
    logic rd;
    logic [6:0] addr;
    logic byte_v;
    logic [7:0] data;
    logic rd_req;
    logic stop;
  } pmbapw_link_t;

  typedef struct packed {
    logic open;
    logic [3:0] val;
  } pmbapw_sel_t;

  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    logic [7:0] code;
    logic [15:0] data;
    logic [3:0] nbytes;
  } pmbapw_wr_t;

  typedef struct packed {
    logic [7:0] code;
    logic chan;
    logic [3:0] idx;
  } pmbapw_rdq_t;

  typedef struct packed {
    logic invalid_data;
    logic refused;
    logic rail_read;
  } pmbapw_cml_t;
endpackage : pmbapw_pkg

// *** rtl/pmbapw_top.sv ***
// PMBus addressing, page selection, page-plus and write-protect front end.
`timescale 1ns/1ps
module pmbapw_top
  import pmbapw_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input pmbapw_link_t link_in,
  input pmbapw_sel_t addr_select_pin_0,
  input pmbapw_sel_t addr_select_pin_1,
  input wire logic [7:0] ext_rd_byte,
  output logic addr_ack,
  output logic byte_ack,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output pmbapw_wr_t wr_out,
  output pmbapw_rdq_t ext_rd,
  output pmbapw_cml_t cml,
  output logic [7:0] page_out,
  output logic [7:0] wl_out,
  output logic ignore_cfg_pins
);
  // ----------------------------------------------------------------
  // Strap pin synchronisers
  // ----------------------------------------------------------------
  logic [9:0] s1_reg, s2_reg, s3_reg, pins_reg;
  // Stages reset to the open pattern, so no false strap change follows reset.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s1_reg <= PINS_OPEN_RESET;
      s2_reg <= PINS_OPEN_RESET;
      s3_reg <= PINS_OPEN_RESET;
    end else begin
      s1_reg <= {addr_select_pin_1, addr_select_pin_0};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // Pins keep their last settled value until they settle; after reset that is open, so the stored address rules meanwhile.
  always_ff @(posedge mclk) begin
    if (!reset_n) pins_reg <= PINS_OPEN_RESET;
    else if (s2_reg == s3_reg) pins_reg <= s3_reg;
  end
  pmbapw_sel_t sel0, sel1;
  assign sel0 = pins_reg[4:0];
  assign sel1 = pins_reg[9:5];

  // ----------------------------------------------------------------
  // Stored settings and transaction state
  // ----------------------------------------------------------------
  pmbapw_state_t state_reg, state_next;
  logic [7:0] page_reg, wl_reg, cfg_reg, dev_addr_reg, rail0_reg, rail1_reg;
  logic [7:0] cmd_reg, pp_page_reg, pp_code_reg, d0_reg, d1_reg;
  logic [3:0] idx_reg, rd_idx_reg;
  logic [1:0] rail_hit_reg;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [6:0] eff_addr;
  logic dev_en, dev_hit, glob_hit, addr_hit;
  logic [1:0] rail_mask;
  assign eff_addr[6:4] = sel1.open ? dev_addr_reg[6:4] : sel1.val[2:0];
  assign eff_addr[3:0] = sel0.open ? dev_addr_reg[3:0] : sel0.val;
  assign dev_en = (dev_addr_reg != ADDR_OFF) || !sel0.open || !sel1.open;
  assign dev_hit = dev_en && (link_in.addr == eff_addr);
  assign glob_hit = (link_in.addr == GLOBAL_ADDR_A) || (link_in.addr == GLOBAL_ADDR_B);
  assign rail_mask[0] = (rail0_reg != ADDR_OFF) && (link_in.addr == rail0_reg[6:0]);
  assign rail_mask[1] = (rail1_reg != ADDR_OFF) && (link_in.addr == rail1_reg[6:0]);
  assign addr_hit = dev_hit || glob_hit || (rail_mask != 2'b00);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  function automatic logic [1:0] page_to_mask(input logic [7:0] pg);
    logic [1:0] m;
    m = 2'b00;
    if (pg == PAGE_CH0) m = 2'b01;
    else if (pg == PAGE_CH1) m = 2'b10;
    else if (pg == PAGE_ALL) m = 2'b11;
    return m;
  endfunction : page_to_mask

  function automatic logic is_paged(input logic [7:0] c);
    return (c == CMD_OPERATION) || (c == CMD_ON_OFF_CONFIG) || (c == CMD_VOUT_COMMAND) ||
           (c == CMD_RAIL_ADDR) || (c == CMD_PROTOCOL_REV) ||
           ((c >= CMD_STATUS_FIRST) && (c <= CMD_STATUS_LAST));
  endfunction : is_paged

  function automatic logic wl_allows(input logic [7:0] lvl, input logic [7:0] c);
    logic base, mid, high;
    base = (c == CMD_WRITE_LOCK) || (c == CMD_PAGE) || (c == CMD_STORE_USER_ALL) ||
           (c == CMD_NVM_UNLOCK);
    mid = base || (c == CMD_OPERATION) || (c == CMD_PEAK_CLEAR) || (c == CMD_CLEAR_FAULTS) ||
          ((c >= CMD_STATUS_FIRST) && (c <= CMD_STATUS_LAST));
    high = mid || (c == CMD_ON_OFF_CONFIG) || (c == CMD_VOUT_COMMAND);
    case (lvl)
      WL_NONE: wl_allows = 1'b1;
      WL_HIGH: wl_allows = high;
      WL_MID: wl_allows = mid;
      default: wl_allows = base;
    endcase
  endfunction : wl_allows

  logic is_pp, is_ppw, is_ppr, nest_err, wr_cand, do_commit, allowed, local_cmd;
  logic [7:0] tc;
  logic [3:0] nb;
  logic [1:0] chan_w;
  logic [7:0] eff_page;
  logic rd_chan;
  assign is_ppw = (cmd_reg == CMD_PAGE_PLUS_WRITE);
  assign is_ppr = (cmd_reg == CMD_PAGE_PLUS_READ);
  assign is_pp = is_ppw || is_ppr;
  assign tc = is_pp ? pp_code_reg : cmd_reg;
  assign nb = is_pp ? (idx_reg - PP_IDX_DATA) : idx_reg;
  // The embedded page acts only for paged targets and only for this packet.
  assign eff_page = (is_pp && is_paged(tc)) ? pp_page_reg : page_reg;
  assign chan_w = (rail_hit_reg != 2'b00) ? rail_hit_reg : page_to_mask(eff_page);
  assign rd_chan = (eff_page == PAGE_CH1);
  assign nest_err = (state_reg == ST_DATA) && link_in.byte_v && is_pp &&
                    (idx_reg == PP_IDX_CODE) &&
                    ((link_in.data == CMD_PAGE_PLUS_WRITE) ||
                     (link_in.data == CMD_PAGE_PLUS_READ));
  assign wr_cand = is_ppw ? (idx_reg > PP_IDX_DATA) : (!is_ppr && (idx_reg != 4'h0));
  assign do_commit = link_in.stop && (state_reg == ST_DATA) && wr_cand;
  assign allowed = wl_allows(wl_reg, tc);
  assign local_cmd = (tc == CMD_PAGE) || (tc == CMD_WRITE_LOCK) || (tc == CMD_DEVICE_CONFIG) ||
                     (tc == CMD_DEVICE_ADDR) || (tc == CMD_RAIL_ADDR) ||
                     (tc == CMD_FEATURE_SUMMARY) || (tc == CMD_PROTOCOL_REV);

  logic page_ok, wl_ok, ro_hit;
  assign page_ok = (page_to_mask(d0_reg) != 2'b00);
  assign wl_ok = (d0_reg == WL_NONE) || (d0_reg == WL_HIGH) || (d0_reg == WL_MID) ||
                 (d0_reg == WL_FULL);
  assign ro_hit = (tc == CMD_FEATURE_SUMMARY) || (tc == CMD_PROTOCOL_REV);

  logic wr_page, wr_wl, wr_cfg, wr_addr, wr_ext, bad_value;
  assign wr_page = do_commit && allowed && (tc == CMD_PAGE) && page_ok;
  assign wr_wl = do_commit && allowed && (tc == CMD_WRITE_LOCK) && wl_ok;
  assign wr_cfg = do_commit && allowed && (tc == CMD_DEVICE_CONFIG);
  assign wr_addr = do_commit && allowed && (tc == CMD_DEVICE_ADDR);
  assign wr_ext = do_commit && allowed && !local_cmd;
  assign bad_value = do_commit && allowed &&
                     (ro_hit || ((tc == CMD_PAGE) && !page_ok) ||
                      ((tc == CMD_WRITE_LOCK) && !wl_ok));

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  logic [7:0] local_byte, rd_byte, blk_len;
  assign local_byte = (tc == CMD_PAGE) ? page_reg :
                      (tc == CMD_WRITE_LOCK) ? wl_reg :
                      (tc == CMD_FEATURE_SUMMARY) ? FEATURE_VALUE :
                      (tc == CMD_PROTOCOL_REV) ? REVISION_VALUE :
                      (tc == CMD_DEVICE_CONFIG) ? cfg_reg :
                      (tc == CMD_DEVICE_ADDR) ? dev_addr_reg :
                      rd_chan ? rail1_reg : rail0_reg;
  assign blk_len = local_cmd ? LOCAL_BLOCK_LEN : EXT_BLOCK_LEN;
  // A page-plus read answers as a block: count first, then the data.
  assign rd_byte = (is_ppr && rd_idx_reg == 4'h0) ? blk_len :
                   (rail_hit_reg != 2'b00) ? 8'hFF :
                   local_cmd ? local_byte : ext_rd_byte;

  // ----------------------------------------------------------------
  // Transaction state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (link_in.start) begin
      state_next = !addr_hit ? ST_IDLE : (link_in.rd ? ST_READ : ST_CMD);
    end else if (link_in.stop) begin
      state_next = ST_IDLE;
    end else if (link_in.byte_v) begin
      case (state_reg)
        ST_CMD: state_next = ST_DATA;
        ST_DATA: state_next = nest_err ? ST_DROP : ST_DATA;
        ST_IDLE: state_next = ST_IDLE;
        ST_READ: state_next = ST_READ;
        ST_DROP: state_next = ST_DROP;
        default: state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) state_reg <= ST_IDLE;
    else state_reg <= state_next;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cmd_reg <= 8'h00;
      idx_reg <= 4'h0;
      pp_page_reg <= 8'h00;
      pp_code_reg <= 8'h00;
      d0_reg <= 8'h00;
      d1_reg <= 8'h00;
      rail_hit_reg <= 2'b00;
      rd_idx_reg <= 4'h0;
    end else begin
      if (link_in.start && addr_hit) begin
        rd_idx_reg <= 4'h0;
        rail_hit_reg <= rail_mask;
        if (!link_in.rd) idx_reg <= 4'h0;
      end
      if (link_in.byte_v && state_reg == ST_CMD) cmd_reg <= link_in.data;
      if (link_in.byte_v && state_reg == ST_DATA) begin
        if (idx_reg != 4'hF) idx_reg <= idx_reg + 4'h1;
        if (is_pp && idx_reg == PP_IDX_PAGE) pp_page_reg <= link_in.data;
        if (is_pp && idx_reg == PP_IDX_CODE) pp_code_reg <= link_in.data;
        if (nb == 4'h0 && (!is_pp || idx_reg >= PP_IDX_DATA)) d0_reg <= link_in.data;
        if (nb == 4'h1 && (!is_pp || idx_reg >= PP_IDX_DATA)) d1_reg <= link_in.data;
      end
      if (link_in.rd_req && state_reg == ST_READ) rd_idx_reg <= rd_idx_reg + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Stored settings; a refused write never reaches them.
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      page_reg <= PAGE_RESET;
      wl_reg <= WL_RESET;
      cfg_reg <= CONFIG_RESET;
      dev_addr_reg <= DEV_ADDR_RESET;
      rail0_reg <= RAIL_ADDR_RESET;
      rail1_reg <= RAIL_ADDR_RESET;
    end else begin
      if (wr_page && !is_pp) page_reg <= d0_reg;
      if (wr_wl) wl_reg <= d0_reg;
      if (wr_cfg) cfg_reg <= d0_reg;
      if (wr_addr) dev_addr_reg <= d0_reg;
      if (do_commit && allowed && tc == CMD_RAIL_ADDR && chan_w[0]) rail0_reg <= d0_reg;
      if (do_commit && allowed && tc == CMD_RAIL_ADDR && chan_w[1]) rail1_reg <= d0_reg;
    end
  end

  // ----------------------------------------------------------------
  // Registered answers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      addr_ack <= 1'b0;
      byte_ack <= 1'b0;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      wr_out <= '0;
      ext_rd <= '0;
      cml <= '0;
    end else begin
      addr_ack <= link_in.start && addr_hit;
      byte_ack <= link_in.byte_v && !nest_err &&
                  (state_reg == ST_CMD || state_reg == ST_DATA);
      rd_valid <= link_in.rd_req && (state_reg == ST_READ);
      if (link_in.rd_req && state_reg == ST_READ) rd_data <= rd_byte;
      wr_out.valid <= wr_ext;
      if (wr_ext) begin
        wr_out.chan <= chan_w;
        wr_out.code <= tc;
        wr_out.data <= {d1_reg, d0_reg};
        wr_out.nbytes <= nb;
      end
      ext_rd.code <= tc;
      ext_rd.chan <= rd_chan;
      ext_rd.idx <= is_ppr ? (rd_idx_reg - 4'h1) : rd_idx_reg;
      cml.invalid_data <= nest_err || bad_value;
      cml.refused <= do_commit && !allowed;
      cml.rail_read <= link_in.start && link_in.rd && !dev_hit && !glob_hit &&
                       (rail_mask != 2'b00);
    end
  end

  assign page_out = page_reg;
  assign wl_out = wl_reg;
  assign ignore_cfg_pins = cfg_reg[CFG_IGNORE_PINS_BIT];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_nested_code;
    nest_err;
  endsequence
  sequence s_dropped;
    !byte_ack && cml.invalid_data && (state_reg == ST_DROP);
  endsequence

  chk_nested_drop: assert property (s_nested_code |=> s_dropped)
    else $error("nested page-plus not dropped");
  chk_bcast_write: assert property (wr_ext && rail_hit_reg == 2'b00 && !is_pp &&
    page_reg == PAGE_ALL |=> wr_out.valid && wr_out.chan == 2'b11)
    else $error("broadcast write not on both channels");
  chk_page_one: assert property (wr_ext && rail_hit_reg == 2'b00 && !is_pp &&
    page_reg == PAGE_CH1 |=> wr_out.chan == 2'b10)
    else $error("page one not mapped to channel 1");
  chk_bcast_read: assert property (state_reg == ST_READ && !is_pp &&
    page_reg == PAGE_ALL |=> !ext_rd.chan)
    else $error("broadcast read not from channel 0");
  chk_pp_page_kept: assert property (do_commit && is_pp |=> $stable(page_reg))
    else $error("page-plus changed stored page");
  chk_full_lock: assert property (do_commit && wl_reg == WL_FULL &&
    tc == CMD_OPERATION |=> !wr_out.valid && cml.refused)
    else $error("locked write accepted");
  chk_mid_lock: assert property (do_commit && wl_reg == WL_MID &&
    tc == CMD_VOUT_COMMAND |=> !wr_out.valid && cml.refused)
    else $error("level 40 accepted output voltage write");
  chk_high_allow: assert property (do_commit && wl_reg == WL_HIGH &&
    tc == CMD_VOUT_COMMAND |=> wr_out.valid && !cml.refused)
    else $error("level 20 refused output voltage write");
  chk_status_clear: assert property (do_commit && tc == CMD_STATUS_FIRST &&
    (wl_reg == WL_MID || wl_reg == WL_HIGH) |=> wr_out.valid)
    else $error("status bit clear refused");
  chk_open_write: assert property (do_commit && wl_reg == WL_NONE &&
    !local_cmd |=> wr_out.valid)
    else $error("unlocked write dropped");
  chk_global_ack: assert property (link_in.start && glob_hit |=> addr_ack)
    else $error("global address not acknowledged");
  chk_addr_off: assert property (link_in.start && dev_addr_reg == ADDR_OFF &&
    sel0.open && sel1.open && !glob_hit && rail_mask == 2'b00 |=> !addr_ack)
    else $error("disabled device address answered");
  chk_pins_override: assert property (link_in.start && !sel0.open && !sel1.open &&
    link_in.addr == {sel1.val[2:0], sel0.val} |=> addr_ack)
    else $error("strap address not answered");
  chk_rail_fault: assert property (link_in.start && link_in.rd && !dev_hit && !glob_hit &&
    rail_mask != 2'b00 |=> addr_ack && cml.rail_read)
    else $error("rail read not flagged");
  chk_revision: assert property (link_in.rd_req && state_reg == ST_READ && !is_pp &&
    rail_hit_reg == 2'b00 && cmd_reg == CMD_PROTOCOL_REV |=> rd_data == REVISION_VALUE)
    else $error("wrong revision byte");
  chk_feature_byte: assert property (link_in.rd_req && state_reg == ST_READ && !is_pp &&
    rail_hit_reg == 2'b00 && cmd_reg == CMD_FEATURE_SUMMARY |=> rd_data == FEATURE_VALUE)
    else $error("wrong feature summary byte");
  sequence s_pp_count_req;
    link_in.rd_req && (state_reg == ST_READ) && is_ppr && (rd_idx_reg == 4'h0);
  endsequence
  chk_pp_count: assert property (s_pp_count_req |=> rd_valid &&
    (rd_data == LOCAL_BLOCK_LEN || rd_data == EXT_BLOCK_LEN))
    else $error("page-plus read count wrong");
endmodule : pmbapw_top

// *** verif/pmbapw_host.sv ***
// Host model that drives the serial engine events toward the front end.
`timescale 1ns/1ps
module pmbapw_host
  import pmbapw_pkg::*;
(
  input wire logic mclk,
  output pmbapw_link_t link,
  input wire logic addr_ack,
  input wire logic byte_ack,
  input wire logic rd_valid
);
  // ----------------------------------------------------------------
  // Event pulses
  // ----------------------------------------------------------------
  // The answer is taken one rising edge after the event; idle address and data
  // then show the inverse of their last value so that nothing stale can match.
  initial link = '0;
  task automatic pulse(input pmbapw_link_t e, output logic a);
    pmbapw_link_t idle;
    idle = '0;
    idle.addr = ~e.addr;
    idle.data = ~e.data;
    @(negedge mclk);
    link = e;
    @(negedge mclk);
    a = e.start ? addr_ack : (e.rd_req ? rd_valid : byte_ack);
    link = idle;
  endtask : pulse
  task automatic start_ph(input logic [6:0] ad, input logic rd, output logic a);
    pmbapw_link_t e;
    e = '0;
    e.start = 1'b1;
    e.addr = ad;
    e.rd = rd;
    pulse(e, a);
  endtask : start_ph
  task automatic put(input logic [7:0] b, output logic a);
    pmbapw_link_t e;
    e = '0;
    e.byte_v = 1'b1;
    e.data = b;
    pulse(e, a);
  endtask : put
  task automatic get(output logic v);
    pmbapw_link_t e;
    e = '0;
    e.rd_req = 1'b1;
    pulse(e, v);
  endtask : get
  task automatic halt();
    pmbapw_link_t e;
    logic a;
    e = '0;
    e.stop = 1'b1;
    pulse(e, a);
  endtask : halt
endmodule : pmbapw_host

// *** verif/pmbus_addressing_page_write_protect_test.sv ***
// Self-checking bench for the addressing, page and write-protect front end.
`timescale 1ns/1ps
module pmbus_addressing_page_write_protect_test import pmbapw_pkg::*;;
  localparam int CYCLE_LIMIT = 20000;
  localparam logic [7:0] RST_CODE [7] = '{8'h00, 8'h10, 8'h19, 8'h98, 8'hD1, 8'hE6, 8'hFA};
  localparam logic [7:0] RST_VAL [7] = '{8'h00, 8'h00, 8'hB0, 8'h22, 8'h01, 8'h4F, 8'h80};
  localparam logic [7:0] PAGE_SEQ [3] = '{8'hFF, 8'h01, 8'h00};
  localparam logic [7:0] WL_SEQ [4] = '{8'h80, 8'h40, 8'h20, 8'h00};
  localparam logic [7:0] WR_CODE [9] = '{8'h21, 8'h01, 8'h02, 8'hE3, 8'h03, 8'h15, 8'hBD, 8'h33,
                                         8'h78};
  logic mclk;
  logic reset_n = 1'b0;
  pmbapw_link_t link_in;
  pmbapw_sel_t pin0 = '{open: 1'b1, val: 4'h0};
  pmbapw_sel_t pin1 = '{open: 1'b1, val: 4'h0};
  logic [7:0] ext_rd_byte = 8'h00;
  logic addr_ack;
  logic byte_ack;
  logic [7:0] rd_data;
  logic rd_valid;
  pmbapw_wr_t wr_out;
  pmbapw_rdq_t ext_rd;
  pmbapw_cml_t cml;
  logic [7:0] page_out;
  logic [7:0] wl_out;
  logic ignore_cfg_pins;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0001_5817;
  pmbapw_top pmbapw_top_inst (.mclk(mclk), .reset_n(reset_n), .link_in(link_in),
    .addr_select_pin_0(pin0), .addr_select_pin_1(pin1), .ext_rd_byte(ext_rd_byte),
    .addr_ack(addr_ack), .byte_ack(byte_ack), .rd_data(rd_data), .rd_valid(rd_valid),
    .wr_out(wr_out), .ext_rd(ext_rd), .cml(cml), .page_out(page_out), .wl_out(wl_out),
    .ignore_cfg_pins(ignore_cfg_pins));
  pmbapw_host pmbapw_host_inst (.mclk(mclk), .link(link_in), .addr_ack(addr_ack),
    .byte_ack(byte_ack), .rd_valid(rd_valid));
  // ----------------------------------------------------------------
  // Expectations and helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd
  function automatic logic [7:0] mem(input pmbapw_rdq_t q);
    return q.code ^ {7'h00, q.chan} ^ 8'h5C;
  endfunction : mem
  function automatic bit allowed(input logic [7:0] lv, input logic [7:0] c);
    bit base = c inside {CMD_WRITE_LOCK, CMD_PAGE, CMD_STORE_USER_ALL, CMD_NVM_UNLOCK};
    bit mid = base || (c inside {CMD_OPERATION, CMD_PEAK_CLEAR, CMD_CLEAR_FAULTS})
              || (c >= CMD_STATUS_FIRST && c <= CMD_STATUS_LAST);
    if (lv == WL_FULL) return base;
    if (lv == WL_MID) return mid;
    if (lv == WL_HIGH) return mid || (c inside {CMD_ON_OFF_CONFIG, CMD_VOUT_COMMAND});
    return 1'b1;
  endfunction : allowed
  task automatic chk(input bit c, input string m);
    total_checks++;
    if (!c) begin
      n_mismatch++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask : chk
  task automatic send(input logic [6:0] a, input logic [7:0] q[$], output logic ok);
    logic k;
    pmbapw_host_inst.start_ph(a, 1'b0, k);
    ok = k;
    foreach (q[i]) begin
      pmbapw_host_inst.put(q[i], k);
      ok = ok & k;
    end
  endtask : send
  task automatic xfer(input logic [6:0] a, input logic [7:0] q[$], output logic ok);
    send(a, q, ok);
    pmbapw_host_inst.halt();
  endtask : xfer
  task automatic rd_reg(input logic [7:0] q[$], input int n, output logic ok,
                        output logic [7:0] d0, output logic [7:0] d1, output pmbapw_rdq_t t);
    logic k;
    send(7'h4F, q, ok);
    pmbapw_host_inst.start_ph(7'h4F, 1'b1, k);
    ok = ok & k;
    for (int i = 0; i < n; i++) begin
      pmbapw_host_inst.get(k);
      ok = ok & k;
      t = ext_rd;
      if (i == 0) d0 = rd_data;
      d1 = rd_data;
    end
    pmbapw_host_inst.halt();
  endtask : rd_reg
  task automatic probe(input logic [6:0] a, input logic e);
    logic k;
    pmbapw_host_inst.start_ph(a, 1'b0, k);
    pmbapw_host_inst.halt();
    chk(k === e, "address match");
  endtask : probe
  task automatic complete_run();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------------------------------
  // Clock, channel memory, watchdog and scenarios
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(negedge mclk) ext_rd_byte <= mem(ext_rd);
  always @(posedge mclk) begin
    cycles++;
    if (cycles == CYCLE_LIMIT) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    logic ok;
    logic k;
    bit e;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] r;
    logic [6:0] a;
    pmbapw_rdq_t t;
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk(page_out === PAGE_RESET && wl_out === WL_RESET && ignore_cfg_pins === 1'b0, "levels");
    foreach (RST_CODE[i]) begin
      rd_reg({RST_CODE[i]}, 1, ok, d0, d1, t);
      chk(ok === 1'b1 && d1 === RST_VAL[i], "reset value");
    end
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      a = (r[6:0] inside {7'h4F, GLOBAL_ADDR_A, GLOBAL_ADDR_B}) ? r[6:0] ^ 7'h10 : r[6:0];
      if (i < 2) a = GLOBAL_ADDR_A | 7'(i);
      probe(a, i < 2);
    end
    foreach (PAGE_SEQ[i]) begin
      xfer(7'h4F, {CMD_PAGE, PAGE_SEQ[i]}, ok);
      r = rnd();
      xfer(7'h4F, {CMD_OPERATION, r}, ok);
      chk(ok && page_out === PAGE_SEQ[i] && wr_out.valid === 1'b1 && wr_out.data[7:0] === r
          && wr_out.chan === {PAGE_SEQ[i] != PAGE_CH0, PAGE_SEQ[i] != PAGE_CH1}, "paged");
      rd_reg({CMD_OPERATION}, 1, ok, d0, d1, t);
      chk(ok && t.chan === (PAGE_SEQ[i] == PAGE_CH1) && d1 === mem(t), "paged read");
    end
    r = rnd();
    xfer(7'h4F, {CMD_PAGE_PLUS_WRITE, 8'h03, PAGE_CH1, CMD_VOUT_COMMAND, r}, ok);
    chk(ok && wr_out.valid === 1'b1 && wr_out.chan === 2'b10 && wr_out.data[7:0] === r
        && wr_out.code === CMD_VOUT_COMMAND && wr_out.nbytes === 4'h1
        && page_out === PAGE_CH0, "pp write");
    xfer(7'h4F, {CMD_PAGE_PLUS_WRITE, 8'h03, PAGE_CH1, CMD_DEVICE_CONFIG, 8'h41}, ok);
    chk(ok && ignore_cfg_pins === 1'b1 && page_out === PAGE_CH0, "pp non-paged");
    xfer(7'h4F, {CMD_FEATURE_SUMMARY, 8'h00}, ok);
    chk(ok && cml.invalid_data === 1'b1 && wr_out.valid === 1'b0, "read-only write");
    xfer(7'h4F, {CMD_PAGE, 8'h02}, ok);
    chk(cml.invalid_data === 1'b1 && page_out === PAGE_CH0, "bad page");
    send(7'h4F, {CMD_PAGE_PLUS_WRITE, 8'h03, PAGE_CH1}, ok);
    pmbapw_host_inst.put(CMD_PAGE_PLUS_READ, k);
    chk(ok && k === 1'b0 && cml.invalid_data === 1'b1, "nested pp");
    pmbapw_host_inst.halt();
    rd_reg({CMD_PAGE_PLUS_READ, 8'h02, PAGE_CH1, CMD_OPERATION}, 2, ok, d0, d1, t);
    chk(ok && d0 === EXT_BLOCK_LEN && t.chan === 1'b1 && t.code === CMD_OPERATION
        && d1 === mem(t) && page_out === PAGE_CH0, "pp read");
    foreach (WL_SEQ[i]) begin
      xfer(7'h4F, {CMD_WRITE_LOCK, WL_SEQ[i]}, ok);
      chk(ok && wl_out === WL_SEQ[i], "protect level");
      foreach (WR_CODE[j]) begin
        r = rnd();
        e = allowed(WL_SEQ[i], WR_CODE[j]);
        if (j == 0)
          xfer(7'h4F, {CMD_PAGE_PLUS_WRITE, 8'h03, PAGE_CH0, WR_CODE[j], r}, ok);
        else
          xfer(7'h4F, {WR_CODE[j], r}, ok);
        chk(ok && wr_out.valid === e && cml.refused === !e && (!e || (wr_out.code === WR_CODE[j]
            && wr_out.data[7:0] === r)), "protect");
      end
    end
    pin0 = '{open: 1'b0, val: 4'h3};
    pin1 = '{open: 1'b0, val: 4'h2};
    repeat (4) @(negedge mclk);
    probe(7'h23, 1'b1);
    probe(7'h4F, 1'b0);
    pin1.open = 1'b1;
    repeat (4) @(negedge mclk);
    probe(7'h43, 1'b1);
    pin0.open = 1'b1;
    repeat (4) @(negedge mclk);
    probe(7'h4F, 1'b1);
    xfer(7'h4F, {CMD_DEVICE_ADDR, ADDR_OFF}, ok);
    probe(7'h4F, 1'b0);
    probe(GLOBAL_ADDR_A, 1'b1);
    xfer(GLOBAL_ADDR_B, {CMD_DEVICE_ADDR, DEV_ADDR_RESET}, ok);
    probe(7'h4F, 1'b1);
    xfer(7'h4F, {CMD_RAIL_ADDR, 8'h30}, ok);
    r = rnd();
    xfer(7'h30, {CMD_OPERATION, r}, ok);
    chk(ok && wr_out.valid === 1'b1 && wr_out.chan === 2'b01 && wr_out.data[7:0] === r, "rail");
    pmbapw_host_inst.start_ph(7'h30, 1'b1, k);
    chk(k === 1'b1 && cml.rail_read === 1'b1, "rail read");
    pmbapw_host_inst.get(k);
    chk(k === 1'b1 && rd_data === 8'hFF, "rail data");
    pmbapw_host_inst.halt();
    complete_run();
  end
endmodule : pmbus_addressing_page_write_protect_test
